// File: design/pwm_shared_period_regs.vh
// register offsets, field positions and reset values of the pwm block
// assumes an 8-bit byte address on a 32-bit axi4-lite slave
`ifndef PWM_SHARED_PERIOD_REGS_VH
`define PWM_SHARED_PERIOD_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define PWM_ADDR_CTRL 8'h00
`define PWM_ADDR_CHAN 8'h04
`define PWM_ADDR_PERIOD 8'h08
`define PWM_ADDR_STATUS 8'h0C
`define PWM_ADDR_MASK 8'h10
`define PWM_ADDR_COUNT 8'h14
`define PWM_ADDR_DUTY0 8'h20
`define PWM_ADDR_DUTY7 8'h3C

// ****************************************
// control register fields
// ****************************************
`define PWM_CTRL_RUN 0
`define PWM_CTRL_CLKSEL 1
`define PWM_CTRL_PSC_LSB 2
`define PWM_CTRL_PSC_MSB 4
`define PWM_CTRL_CENTER 5
`define PWM_CTRL_COMP 6
`define PWM_CTRL_DT_LSB 8
`define PWM_CTRL_DT_MSB 15

// ****************************************
// channel register fields
// ****************************************
`define PWM_CHAN_EN_LSB 0
`define PWM_CHAN_EN_MSB 7
`define PWM_CHAN_INV_LSB 8
`define PWM_CHAN_INV_MSB 15

// ****************************************
// status fields
// ****************************************
`define PWM_STS_OVF 0
`define PWM_STS_FLT 1
`define PWM_STS_FLT_PIN 8
`define PWM_STS_DOWN 9

// ****************************************
// reset values and bus answers
// ****************************************
`define PWM_RST_CTRL 16'h0000
`define PWM_RST_CHAN 16'h0000
`define PWM_RST_PERIOD 16'h00FF
`define PWM_RST_DUTY 16'h0000
`define PWM_RST_MASK 2'h0
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// File: design/pwm_shared_period.v
// eight-channel 16-bit pwm generator with one shared period, axi4-lite slave
// assumes i_ref_clk is the peripheral bus clock; fast oscillator and fault arrive asynchronously
//
// Summary of operation
// - eight outputs are compared against one 16-bit counter running on one common period.
// - software picks the counter source: the bus clock or the internal fast oscillator.
// - the chosen source is divided by 1, 2, 4 up to 128 before it advances the counter.
// - the counter advances at most once per source clock, so no output toggles faster.
// - each channel has its own enable, inversion and duty value.
// - an inverted channel drives the complement of its normal waveform.
// - all channels follow one edge-aligned or center-aligned counting scheme.
// - in independent mode every channel compares its own duty against the shared counter.
// - in complementary mode channels form four pairs, the odd one the inverse of the even one.
// - a single overflow event fires each time the counter finishes a period.
// - a synchronised fault input is watched continuously.
// - overflow and fault keep separate sticky flags.
// - duty writes go to a shadow copy that is loaded at the period boundary, and every cycle while the counter is stopped.
// - period writes are shadowed the same way and loaded at the period boundary.

`include "pwm_shared_period_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module pwm_shared_period (
  // clock and reset
  input wire i_ref_clk,
  input wire i_rst_b,
  // asynchronous inputs
  input wire i_fast_osc_clk,
  input wire i_fault,
  // axi4-lite write address and data
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [7:0] i_s_axi_awaddr,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  // axi4-lite write response
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  output reg [1:0] o_s_axi_bresp,
  // axi4-lite read
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  input wire [7:0] i_s_axi_araddr,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  // pwm outputs and interrupt
  output reg [7:0] o_pwm,
  output reg o_irq
);

  // ****************************************
  // byte-lane merge
  // ****************************************
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0] strb;
    integer b;
    begin
      wmerge = old;
      for (b = 0; b < 4; b = b + 1)
      begin
        if (strb[b])
          wmerge[8*b +: 8] = dat[8*b +: 8];
      end
    end
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  reg aw_have_q, w_have_q, down_q, osc_s1_q, osc_s2_q, osc_s3_q, flt_s1_q, flt_s2_q, rd_ok;
  reg [1:0] sts_q, mask_q;
  reg [3:0] wstrb_q;
  reg [6:0] psc_q;
  reg [7:0] awaddr_q;
  reg [15:0] ctrl_q, chan_q, per_sh_q, per_act_q, cnt_q;
  reg [31:0] wdata_q, rd_data;
  wire aw_fire, w_fire, do_wr, b_fire, ar_fire, r_fire, aw_have_d, w_have_d, bvalid_d, rvalid_d;
  wire run, center, comp, src_tick, tick, wrap, load;
  wire [1:0] sts_set, sts_clr;
  wire [2:0] psc_sel, rd_idx;
  wire [6:0] psc_lim;
  wire [7:0] raw, pwm_d, dead, psc_div;
  wire [31:0] wfull, ctrl_w, chan_w, per_w, mask_w;
  wire [127:0] duty_sh_all;

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  assign aw_fire = i_s_axi_awvalid & o_s_axi_awready;
  assign w_fire = i_s_axi_wvalid & o_s_axi_wready;
  assign do_wr = aw_have_q & w_have_q & ~o_s_axi_bvalid;
  assign b_fire = o_s_axi_bvalid & i_s_axi_bready;
  assign aw_have_d = aw_fire | (aw_have_q & ~do_wr);
  assign w_have_d = w_fire | (w_have_q & ~do_wr);
  assign bvalid_d = do_wr | (o_s_axi_bvalid & ~b_fire);
  assign wfull = wmerge(32'h00000000, wdata_q, wstrb_q);
  assign ctrl_w = wmerge({16'h0000, ctrl_q}, wdata_q, wstrb_q);
  assign chan_w = wmerge({16'h0000, chan_q}, wdata_q, wstrb_q);
  assign per_w = wmerge({16'h0000, per_sh_q}, wdata_q, wstrb_q);
  assign mask_w = wmerge({30'h00000000, mask_q}, wdata_q, wstrb_q);

  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `AXI_RESP_OKAY;
      ctrl_q <= `PWM_RST_CTRL;
      chan_q <= `PWM_RST_CHAN;
      per_sh_q <= `PWM_RST_PERIOD;
      mask_q <= `PWM_RST_MASK;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      o_s_axi_bvalid <= bvalid_d;
      // one write at a time: stay closed until the response is taken
      o_s_axi_awready <= ~aw_have_d & ~bvalid_d;
      o_s_axi_wready <= ~w_have_d & ~bvalid_d;
      if (aw_fire)
        awaddr_q <= i_s_axi_awaddr;
      if (w_fire)
      begin
        wdata_q <= i_s_axi_wdata;
        wstrb_q <= i_s_axi_wstrb;
      end
      if (do_wr)
      begin
        o_s_axi_bresp <= `AXI_RESP_OKAY;
        case (awaddr_q)
          `PWM_ADDR_CTRL: ctrl_q <= ctrl_w[15:0];
          `PWM_ADDR_CHAN: chan_q <= chan_w[15:0];
          `PWM_ADDR_PERIOD: per_sh_q <= per_w[15:0];
          `PWM_ADDR_MASK: mask_q <= mask_w[1:0];
          `PWM_ADDR_STATUS: ;
          `PWM_ADDR_COUNT: ;
          default:
          begin
            if (awaddr_q < `PWM_ADDR_DUTY0 || awaddr_q > `PWM_ADDR_DUTY7 || awaddr_q[1:0] != 2'h0)
              o_s_axi_bresp <= `AXI_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // ****************************************
  // clock source, prescaler and synchronisers
  // ****************************************
  assign run = ctrl_q[`PWM_CTRL_RUN];
  assign center = ctrl_q[`PWM_CTRL_CENTER];
  assign comp = ctrl_q[`PWM_CTRL_COMP];
  assign psc_sel = ctrl_q[`PWM_CTRL_PSC_MSB:`PWM_CTRL_PSC_LSB];
  assign dead = ctrl_q[`PWM_CTRL_DT_MSB:`PWM_CTRL_DT_LSB];
  assign psc_div = 8'h01 << psc_sel;
  assign psc_lim = psc_div[6:0] - 7'h01;
  // oscillator edge seen on the second and third stage only
  assign src_tick = ctrl_q[`PWM_CTRL_CLKSEL] ? (osc_s2_q & ~osc_s3_q) : 1'b1;
  assign tick = run & src_tick & (psc_q == psc_lim);

  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      flt_s1_q <= 1'b0;
      flt_s2_q <= 1'b0;
      psc_q <= 7'h00;
    end
    else
    begin
      osc_s1_q <= i_fast_osc_clk;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      flt_s1_q <= i_fault;
      flt_s2_q <= flt_s1_q;
      if (!run)
        psc_q <= 7'h00;
      else if (src_tick)
        psc_q <= (psc_q == psc_lim) ? 7'h00 : psc_q + 7'h01;
    end
  end

  // ****************************************
  // shared counter
  // ****************************************
  // period ends when the count returns to zero
  assign wrap = tick & (center ? (down_q & (cnt_q <= 16'h0001)) : (cnt_q >= per_act_q));
  assign load = wrap | ~run;

  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_q <= 16'h0000;
      down_q <= 1'b0;
      per_act_q <= `PWM_RST_PERIOD;
    end
    else
    begin
      if (load)
        per_act_q <= per_sh_q;
      if (!run)
      begin
        cnt_q <= 16'h0000;
        down_q <= 1'b0;
      end
      else if (tick)
      begin
        if (!center)
          cnt_q <= (cnt_q >= per_act_q) ? 16'h0000 : cnt_q + 16'h0001;
        else if (!down_q)
        begin
          if (cnt_q >= per_act_q)
          begin
            down_q <= 1'b1;
            cnt_q <= (per_act_q == 16'h0000) ? 16'h0000 : cnt_q - 16'h0001;
          end
          else
            cnt_q <= cnt_q + 16'h0001;
        end
        else if (cnt_q <= 16'h0001)
        begin
          down_q <= 1'b0;
          cnt_q <= 16'h0000;
        end
        else
          cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  // ****************************************
  // per-channel duty, dead time and output
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_ch
      reg [15:0] duty_sh_q;
      reg [15:0] duty_act_q;
      reg [7:0] dt_q;
      reg act_q;
      wire want;
      wire [31:0] duty_w;
      assign duty_w = wmerge({16'h0000, duty_sh_q}, wdata_q, wstrb_q);
      assign duty_sh_all[16*i +: 16] = duty_sh_q;
      assign raw[i] = cnt_q < duty_act_q;
      // odd member of a pair mirrors its even partner; index stays in range for even members
      assign want = (comp && (i % 2 == 1)) ? ~raw[i - i % 2] : raw[i];
      // disabled, stopped or faulted channels drive their inactive level
      assign pwm_d[i] = (chan_q[`PWM_CHAN_EN_LSB + i] && run && !sts_q[`PWM_STS_FLT]) ?
        (act_q ^ chan_q[`PWM_CHAN_INV_LSB + i]) : chan_q[`PWM_CHAN_INV_LSB + i];

      always @(posedge i_ref_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          duty_sh_q <= `PWM_RST_DUTY;
          duty_act_q <= `PWM_RST_DUTY;
          dt_q <= 8'h00;
          act_q <= 1'b0;
        end
        else
        begin
          if (do_wr && awaddr_q == `PWM_ADDR_DUTY0 + 8'h04 * i)
            duty_sh_q <= duty_w[15:0];
          if (load)
            duty_act_q <= duty_sh_q;
          if (!comp)
          begin
            act_q <= want;
            dt_q <= 8'h00;
          end
          else if (!want)
          begin
            act_q <= 1'b0;
            dt_q <= dead;
          end
          else if (!act_q)
          begin
            if (dt_q == 8'h00)
              act_q <= 1'b1;
            else if (tick)
              dt_q <= dt_q - 8'h01;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // status flags and interrupt
  // ****************************************
  assign sts_set = {flt_s2_q, wrap};
  assign sts_clr = (do_wr && awaddr_q == `PWM_ADDR_STATUS) ? wfull[1:0] : 2'h0;

  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sts_q <= 2'h0;
      o_irq <= 1'b0;
      o_pwm <= 8'h00;
    end
    else
    begin
      // a new event wins over a clear in the same cycle
      sts_q <= sts_set | (sts_q & ~sts_clr);
      o_irq <= |(sts_q & mask_q);
      o_pwm <= pwm_d;
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  assign ar_fire = i_s_axi_arvalid & o_s_axi_arready;
  assign r_fire = o_s_axi_rvalid & i_s_axi_rready;
  assign rvalid_d = ar_fire | (o_s_axi_rvalid & ~r_fire);
  assign rd_idx = i_s_axi_araddr[4:2];

  always @*
  begin
    rd_data = 32'h00000000;
    rd_ok = 1'b1;
    case (i_s_axi_araddr)
      `PWM_ADDR_CTRL: rd_data = {16'h0000, ctrl_q};
      `PWM_ADDR_CHAN: rd_data = {16'h0000, chan_q};
      `PWM_ADDR_PERIOD: rd_data = {16'h0000, per_sh_q};
      `PWM_ADDR_STATUS: rd_data = {22'h000000, down_q, flt_s2_q, 6'h00, sts_q};
      `PWM_ADDR_MASK: rd_data = {30'h00000000, mask_q};
      `PWM_ADDR_COUNT: rd_data = {16'h0000, cnt_q};
      default:
      begin
        if (i_s_axi_araddr >= `PWM_ADDR_DUTY0 && i_s_axi_araddr <= `PWM_ADDR_DUTY7 &&
            i_s_axi_araddr[1:0] == 2'h0)
          rd_data = {16'h0000, duty_sh_all[16*rd_idx +: 16]};
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h00000000;
      o_s_axi_rresp <= `AXI_RESP_OKAY;
    end
    else
    begin
      o_s_axi_rvalid <= rvalid_d;
      o_s_axi_arready <= ~rvalid_d;
      if (ar_fire)
      begin
        o_s_axi_rdata <= rd_data;
        o_s_axi_rresp <= rd_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end
    end
  end

endmodule

`default_nettype wire

// File: verif/pwm_shared_period_checker.sv
// checker: bus handshakes, fault hold and irq timing of the pwm block
// assumes it is bound to pwm_shared_period and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module pwm_shared_period_checker (
  // clock, reset, fault pin
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_fault,
  // bus handshakes
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  // outputs
  input wire logic [7:0] o_pwm,
  input wire logic o_irq
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  // ****************************************
  // assertions
  // ****************************************
  b_timing_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
    |-> ##2 o_s_axi_bvalid) else $error("write answer not two cycles after take");
  b_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
    else $error("write answer dropped early");
  r_timing_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer not one cycle after take");
  r_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read answer changed before taken");
  ar_refuse_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read address accepted while answer pending");
  aw_refuse_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write accepted while answer pending");
  fault_hold_a: assert property (i_fault [*6] |-> $stable(o_pwm))
    else $error("outputs moved during fault");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(o_s_axi_bvalid))
    else $error("interrupt cleared without a register write");

  // ****************************************
  // covers
  // ****************************************
  irq_seen_c: cover property ($rose(o_irq));
  fault_seen_c: cover property (i_fault [*6]);
  slverr_seen_c: cover property (o_s_axi_rvalid && o_s_axi_rresp == 2'h2);
endmodule

bind pwm_shared_period pwm_shared_period_checker u_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
  .i_fault(i_fault), .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
  .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid),
  .i_s_axi_bready(i_s_axi_bready), .o_s_axi_bresp(o_s_axi_bresp), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
  .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp), .o_pwm(o_pwm), .o_irq(o_irq));

`default_nettype wire

// File: verif/testbench.sv
// testbench: register accesses over axi4-lite and pwm waveform measurements
// assumes the checker is bound in; fast oscillator is made from the bus clock
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic i_ref_clk, i_rst_b, i_fault;
  logic i_fast_osc_clk = 1'b0;
  logic [1:0] osc_cnt = 2'h0;
  logic i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_irq;
  logic [7:0] i_s_axi_awaddr, i_s_axi_araddr, o_pwm;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata, v, hi, lo;
  logic [3:0] i_s_axi_wstrb;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, r;
  int error_cnt, samples_checked;

  pwm_shared_period u_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_fast_osc_clk(i_fast_osc_clk),
    .i_fault(i_fault), .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
    .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
    .i_s_axi_wdata(i_s_axi_wdata), .i_s_axi_wstrb(i_s_axi_wstrb), .o_s_axi_bvalid(o_s_axi_bvalid),
    .i_s_axi_bready(i_s_axi_bready), .o_s_axi_bresp(o_s_axi_bresp), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .i_s_axi_araddr(i_s_axi_araddr), .o_s_axi_rvalid(o_s_axi_rvalid),
    .i_s_axi_rready(i_s_axi_rready), .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp),
    .o_pwm(o_pwm), .o_irq(o_irq));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  // fast oscillator: one rising edge every six bus clocks
  always @(posedge i_ref_clk)
  begin
    osc_cnt <= (osc_cnt == 2'h2) ? 2'h0 : osc_cnt + 2'h1;
    if (osc_cnt == 2'h2)
      i_fast_osc_clk <= ~i_fast_osc_clk;
  end

  // ****************************************
  // tasks
  // ****************************************
  task close_out;
    begin
      if (error_cnt == 0 && samples_checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task step(inout int n);
    begin
      @(posedge i_ref_clk);
      n++;
      if (n > 5000)
      begin
        error_cnt++;
        close_out;
      end
    end
  endtask

  task check(input logic [63:0] g, input logic [63:0] e);
    begin
      samples_checked++;
      if (g !== e)
      begin
        error_cnt++;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, done;
    int n;
    begin
      aw = 1'b1;
      w = 1'b1;
      done = 1'b0;
      n = 0;
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= d;
      i_s_axi_bready <= 1'b0;
      while (!done)
      begin
        step(n);
        // bready follows the answer, so the slave has to hold it meanwhile
        if (o_s_axi_bvalid === 1'b1 && !aw && !w)
        begin
          if (i_s_axi_bready)
          begin
            r = o_s_axi_bresp;
            done = 1'b1;
          end
          else
            i_s_axi_bready <= 1'b1;
        end
        if (aw && o_s_axi_awready === 1'b1)
        begin
          aw = 1'b0;
          i_s_axi_awvalid <= 1'b0;
        end
        if (w && o_s_axi_wready === 1'b1)
        begin
          w = 1'b0;
          i_s_axi_wvalid <= 1'b0;
        end
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    begin
      n = 0;
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_araddr <= a;
      step(n);
      while (o_s_axi_arready !== 1'b1)
        step(n);
      i_s_axi_arvalid <= 1'b0;
      i_s_axi_rready <= 1'b0;
      step(n);
      while (o_s_axi_rvalid !== 1'b1)
        step(n);
      // rready follows the answer, so the slave has to hold the data meanwhile
      i_s_axi_rready <= 1'b1;
      step(n);
      v = o_s_axi_rdata;
      r = o_s_axi_rresp;
    end
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    begin
      rd(a);
      check(v, e);
    end
  endtask

  // high and low run lengths of one full period, starting at a rising edge
  task automatic measure(input int ch);
    int n;
    begin
      n = 0;
      hi = 0;
      lo = 0;
      while (o_pwm[ch] !== 1'b0)
        step(n);
      while (o_pwm[ch] !== 1'b1)
        step(n);
      while (o_pwm[ch] === 1'b1)
      begin
        step(n);
        hi++;
      end
      while (o_pwm[ch] === 1'b0)
      begin
        step(n);
        lo++;
      end
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    int n;
    {i_rst_b, i_fault, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_arvalid} = 5'h00;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = 48'h0;
    {i_s_axi_bready, i_s_axi_rready, i_s_axi_wstrb} = 6'h3F;
    error_cnt = 0;
    samples_checked = 0;
    repeat (2) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h08, 32'hFF);
    rd_chk(8'h20, 32'h0);
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h18, 32'h0);
    check({30'h0, r}, 32'h2);
    wr(8'h18, 32'h1);
    check({30'h0, r}, 32'h2);
    wr(8'h08, 32'h13);
    wr(8'h20, 32'hC);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h1);
    measure(0);
    check({hi, lo}, {32'hC, 32'h8});
    wr(8'h20, 32'h2);
    // still inside the old high phase: an early load would already show low here
    repeat (3) @(posedge i_ref_clk);
    check({31'h0, o_pwm[0]}, 32'h1);
    measure(0);
    check({hi, lo}, {32'h2, 32'h12});
    wr(8'h08, 32'h9);
    measure(0);
    check({hi, lo}, {32'h2, 32'h8});
    wr(8'h04, 32'h101);
    measure(0);
    check({hi, lo}, {32'h8, 32'h2});
    wr(8'h04, 32'h1);
    for (n = 0; n < 8; n++)
    begin
      wr(8'h00, 32'h1 | (32'(n) << 2));
      measure(0);
      check({hi, lo}, {32'h2 << n, 32'h8 << n});
    end
    wr(8'h00, 32'h21);
    measure(0);
    check({hi, lo}, {32'h3, 32'hF});
    wr(8'h20, 32'h4);
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h241);
    measure(0);
    check({hi, lo}, {32'h2, 32'h8});
    measure(1);
    check({hi, lo}, {32'h4, 32'h6});
    wr(8'h00, 32'h1);
    wr(8'h04, 32'hFF);
    for (n = 0; n < 8; n++)
      wr(8'h20 + 8'(4 * n), 32'(n + 1));
    for (n = 0; n < 8; n++)
    begin
      measure(n);
      check({hi, lo}, {32'(n + 1), 32'(9 - n)});
    end
    wr(8'h10, 32'h1);
    n = 0;
    while (o_irq !== 1'b1)
      step(n);
    rd(8'h0C);
    check({31'h0, v[0]}, 32'h1);
    wr(8'h10, 32'h0);
    repeat (2) @(posedge i_ref_clk);
    check({31'h0, o_irq}, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h0C, 32'h1);
    rd(8'h0C);
    check({30'h0, v[1:0]}, 32'h0);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h1);
    wr(8'h20, 32'h5);
    wr(8'h10, 32'h2);
    i_fault <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    repeat (20)
    begin
      @(posedge i_ref_clk);
      check({24'h0, o_pwm}, 32'h0);
    end
    check({31'h0, o_irq}, 32'h1);
    wr(8'h0C, 32'h2);
    rd(8'h0C);
    check(v & 32'h102, 32'h102);
    i_fault <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    wr(8'h0C, 32'h2);
    rd(8'h0C);
    check({31'h0, v[1]}, 32'h0);
    measure(0);
    check({hi, lo}, {32'h5, 32'h5});
    wr(8'h00, 32'h3);
    measure(0);
    check({hi, lo}, {32'h1E, 32'h1E});
    close_out;
  end
endmodule

`default_nettype wire
